/* File: hw/fprs_nv_store.sv */
/*
  small nonvolatile store for protection, security and boot space map words.
  assumes the writer is the test port logic on the same clock.
  contents survive the reset pin; only the read register is reset.
*/
`timescale 1ns/10ps
module fprs_nv_store #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rst_b_i,
  // write port
  input  wire logic         wr_en_i,
  input  wire logic [1:0]   wr_addr_i,
  input  wire logic [W-1:0] wr_data_i,
  // read port
  input  wire logic [1:0]   rd_addr_i,
  output logic      [W-1:0] rd_data_o
);
  import fprs_pkg::*;
  // programmed contents; the reset pin must not wipe protection settings
  logic [W-1:0] mem_r [4] = '{W'(NV_MAIN_INIT), W'(NV_BOOT_INIT), W'(NV_MAP_INIT), '0};
  // test port writes
  always_ff @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
  end
  // registered read
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= mem_r[rd_addr_i];
    end
  end
endmodule // fprs_nv_store

/* File: hw/fprs_pkg.sv */
/*
  constants, state encoding and register map of the flash protect, reset
  and memory select block.
  assumes a 20 mhz system clock and an 8-bit mcu bus with active-low strobes.
*/
// What this block does
// RULE_01: each flash sector has its own protection bit
// RULE_02: protection bits change only through test port
// RULE_03: program or erase of protected sector ignored
// RULE_04: verify of protected sector reads stored data
// RULE_05: reset command single write, unlock prefix allowed
// RULE_06: controller issues reset after status or error
// RULE_07: reset command ignored during program or bulk erase
// RULE_08: reset aborts sector erase, read within 25 us
// RULE_09: reset after error gives read within 25 us
// RULE_10: oldest variant reset may take milliseconds
// RULE_11: reset pin aborts flash cycle, forces read mode
// RULE_12: external reset pulse held at least 25 us
// RULE_13: main status bit i shows sector i protected
// RULE_14: boot status bits 3-0 protection, bit 7 security
// RULE_15: sram answers only while its select is high
// RULE_16: boot sector select beats main sector select
// RULE_17: sram, io and peripheral beat flash selects
// RULE_18: decode windows must not overlap within level
// RULE_19: three select priority levels, level one highest
// RULE_20: space map loads at boot, mcu may rewrite
// RULE_21: space map bits gate fetch and read access
// RULE_22: space map 0ch gives separated spaces
// RULE_23: protection loaded before first mcu access
package fprs_pkg;
  // register offsets inside the config io space
  localparam logic [7:0] OFS_MAIN_LOCK = 8'hC0;
  localparam logic [7:0] OFS_BOOT_LOCK = 8'hC2;
  localparam logic [7:0] OFS_SPACE_MAP = 8'hB0;
  // nonvolatile store word indices
  localparam logic [1:0] NV_MAIN = 2'h0;
  localparam logic [1:0] NV_BOOT = 2'h1;
  localparam logic [1:0] NV_MAP  = 2'h2;
  localparam logic [1:0] NV_LAST = 2'h3;
  // nonvolatile initial contents
  localparam logic [7:0] NV_MAIN_INIT = 8'h00;
  localparam logic [7:0] NV_BOOT_INIT = 8'h00;
  localparam logic [7:0] NV_MAP_INIT  = 8'h0C;
  // command cycles
  localparam logic [15:0] UNLK_ADDR1 = 16'h0555;
  localparam logic [15:0] UNLK_ADDR2 = 16'h0AAA;
  localparam logic [7:0]  UNLK_DATA1 = 8'hAA;
  localparam logic [7:0]  UNLK_DATA2 = 8'h55;
  localparam logic [7:0]  CMD_RESET  = 8'hF0;
  localparam logic [7:0]  CMD_PROG   = 8'hA0;
  localparam logic [7:0]  CMD_ERASE  = 8'h80;
  localparam logic [7:0]  CMD_BULK   = 8'h10;
  localparam logic [7:0]  CMD_SECT   = 8'h30;
  // space map and boot status field positions
  localparam int MAP_PF_RAM  = 0;
  localparam int MAP_PF_BOOT = 1;
  localparam int MAP_PF_MAIN = 2;
  localparam int MAP_RD_BOOT = 3;
  localparam int MAP_RD_MAIN = 4;
  localparam int MAP_PERIPH_EN = 7;
  localparam int BOOT_SEC_BIT = 7;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_RECOVER_NS  = 25000;
  localparam int T_OLD_RESET_US = 3000;
  localparam int RECOVER_CYC = T_RECOVER_NS / CLK_PERIOD_NS;
  localparam int OLD_RESET_CYC = (T_OLD_RESET_US * 1000) / CLK_PERIOD_NS;
  // sequencer states
  typedef enum logic [3:0] {
    ST_LOAD    = 4'b0000,
    ST_READ    = 4'b0001,
    ST_UNLK1   = 4'b0010,
    ST_UNLK2   = 4'b0011,
    ST_PDATA   = 4'b0100,
    ST_ERS0    = 4'b0101,
    ST_ERS1    = 4'b0110,
    ST_ERS2    = 4'b0111,
    ST_PROG    = 4'b1000,
    ST_BULK    = 4'b1001,
    ST_SECT    = 4'b1010,
    ST_ERR     = 4'b1011,
    ST_RECOVER = 4'b1100
  } fprs_st_t;
endpackage

/* File: hw/fprs_top.sv */
/*
  flash command sequencer with sector protection, reset handling and
  memory select priority with program/data space mapping.
  assumes mcu pins are asynchronous and the flash array is on ref_clk_i.
*/
`timescale 1ns/10ps
module fprs_top
  import fprs_pkg::*;
#(
  parameter bit NEWER_VARIANT = 1'b1,
  parameter int OLD_RST_CYC   = OLD_RESET_CYC
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  // mcu bus pins
  input  wire logic [15:0] bus_addr_i,
  input  wire logic [7:0]  bus_data_i,
  input  wire logic        wr_strobe_b_i,
  input  wire logic        rd_strobe_b_i,
  input  wire logic        program_fetch_strobe_b_i,
  // decode logic array selects
  input  wire logic [7:0]  main_sector_selects_i,
  input  wire logic [3:0]  boot_sector_selects_i,
  input  wire logic        ram_select_i,
  input  wire logic        config_io_space_i,
  input  wire logic        periph_select_i,
  // test port
  input  wire logic        tp_wr_i,
  input  wire logic [1:0]  tp_addr_i,
  input  wire logic [7:0]  tp_data_i,
  // flash array status
  input  wire logic        fl_done_i,
  input  wire logic        fl_fail_i,
  // bus answers
  output logic             bus_ready_o,
  output logic      [7:0]  rd_data_o,
  output logic             rd_valid_o,
  // resolved selects
  output logic      [7:0]  sel_main_o,
  output logic      [3:0]  sel_boot_o,
  output logic             sel_ram_o,
  output logic             sel_io_o,
  output logic             sel_periph_o,
  // flash array control
  output logic             fl_prog_o,
  output logic             fl_erase_o,
  output logic             fl_bulk_o,
  output logic             fl_abort_o,
  output logic             fl_boot_o,
  output logic      [2:0]  fl_sector_o,
  output logic      [15:0] fl_addr_o,
  output logic      [7:0]  fl_data_o,
  output logic             error_flag_bit_o,
  output logic             read_mode_o
);
  import fprs_pkg::*;

  localparam int PIN_W = 53;
  localparam logic [15:0] REC_NEW = 16'(RECOVER_CYC);
  localparam logic [15:0] REC_OLD = 16'(OLD_RST_CYC);

  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic        wr_prev;
    logic        rd_prev;
    logic        tp_prev;
    fprs_st_t    st;
    logic [15:0] cnt;
    logic [1:0]  load_idx;
    logic [7:0]  main_prot;
    logic [3:0]  boot_prot;
    logic        sec_bit;
    logic [7:0]  space_map;
    logic        err;
    logic        ready;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic [7:0]  sel_main;
    logic [3:0]  sel_boot;
    logic        sel_ram;
    logic        sel_io;
    logic        sel_per;
    logic        prog;
    logic        erase;
    logic        bulk;
    logic        abort;
    logic        tboot;
    logic [2:0]  tsec;
    logic [15:0] taddr;
    logic [7:0]  tdata;
    logic [15:0] rec_seen;
    logic        rmode;
  } fprs_state_t;

  fprs_state_t r;
  fprs_state_t r_nxt;
  logic [7:0]  nv_rd_data;

  // lowest set bit of a sector select vector
  function automatic logic [2:0] oh_idx(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // unpacked synchronised pins
  logic [15:0] p_addr;
  logic [7:0]  p_data;
  logic        p_wr;
  logic        p_rd;
  logic        p_pf;
  logic [7:0]  p_main;
  logic [3:0]  p_boot;
  logic        p_ram;
  logic        p_io;
  logic        p_per;
  logic        p_tpwr;
  logic [1:0]  p_tpa;
  logic [7:0]  p_tpd;
  assign {p_addr, p_data, p_wr, p_rd, p_pf, p_main, p_boot,
          p_ram, p_io, p_per, p_tpwr, p_tpa, p_tpd} = r.s2;

  // bus events and write target
  logic       wr_ev;
  logic       rd_ev;
  logic       tp_ev;
  logic       high_lvl;
  logic       t_boot;
  logic       t_any;
  logic [2:0] t_idx;
  logic       t_prot;
  logic       bank_prot;
  logic       is_reset;
  assign wr_ev    = p_wr & ~r.wr_prev;
  assign rd_ev    = (p_rd | p_pf) & ~r.rd_prev;
  assign tp_ev    = p_tpwr & ~r.tp_prev;
  assign high_lvl = p_ram | p_io | p_per;
  assign t_boot   = |p_boot;
  assign t_any    = (t_boot | (|p_main)) & ~high_lvl;
  assign t_idx    = t_boot ? oh_idx({4'h0, p_boot}) : oh_idx(p_main);
  assign t_prot   = t_boot ? r.boot_prot[t_idx[1:0]] : r.main_prot[t_idx];
  assign bank_prot = t_boot ? (|r.boot_prot) : (|r.main_prot);
  assign is_reset = wr_ev & (p_data == CMD_RESET);

  fprs_nv_store #(.W(8)) u_nv (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .wr_en_i   (tp_ev),
    .wr_addr_i (p_tpa),
    .wr_data_i (p_tpd),
    .rd_addr_i (r.load_idx),
    .rd_data_o (nv_rd_data)
  );

  // next state of the whole block
  always_comb begin
    r_nxt = r;
    r_nxt.s1 = {bus_addr_i, bus_data_i, ~wr_strobe_b_i, ~rd_strobe_b_i,
                ~program_fetch_strobe_b_i, main_sector_selects_i,
                boot_sector_selects_i, ram_select_i, config_io_space_i,
                periph_select_i, tp_wr_i, tp_addr_i, tp_data_i};
    r_nxt.s2 = r.s1;
    r_nxt.wr_prev = p_wr;
    r_nxt.rd_prev = p_rd | p_pf;
    r_nxt.tp_prev = p_tpwr;
    r_nxt.prog  = 1'b0;
    r_nxt.erase = 1'b0;
    r_nxt.abort = 1'b0;
    r_nxt.rd_valid = 1'b0;
    // select priority: sram, io, peripheral, then boot, then main
    r_nxt.sel_ram  = p_ram & (~p_pf | r.space_map[MAP_PF_RAM]); // RULE_15 RULE_21
    r_nxt.sel_io   = p_io & ~p_ram;
    r_nxt.sel_per  = p_per & r.space_map[MAP_PERIPH_EN] & ~p_ram & ~p_io; // RULE_21
    r_nxt.sel_boot = high_lvl ? 4'h0 : p_boot; // RULE_17 RULE_19
    r_nxt.sel_main = (high_lvl | t_boot) ? 8'h00 : p_main; // RULE_16 RULE_19 RULE_04
    if (p_pf) begin
      // program fetch space gating, e.g. 0ch keeps main flash only
      if (!r.space_map[MAP_PF_BOOT]) r_nxt.sel_boot = 4'h0; // RULE_21 RULE_22
      if (!r.space_map[MAP_PF_MAIN]) r_nxt.sel_main = 8'h00; // RULE_21 RULE_22
    end else if (p_rd) begin
      if (!r.space_map[MAP_RD_BOOT]) r_nxt.sel_boot = 4'h0; // RULE_21 RULE_22
      if (!r.space_map[MAP_RD_MAIN]) r_nxt.sel_main = 8'h00; // RULE_21 RULE_22
    end
    // status and map reads from config io space
    if (rd_ev && p_rd && p_io && r.ready) begin
      r_nxt.rd_valid = 1'b1;
      case (p_addr[7:0])
        OFS_MAIN_LOCK: r_nxt.rd_data = r.main_prot; // RULE_13
        OFS_BOOT_LOCK: r_nxt.rd_data = {r.sec_bit, 3'h0, r.boot_prot}; // RULE_14
        OFS_SPACE_MAP: r_nxt.rd_data = r.space_map;
        default:       r_nxt.rd_data = 8'h00;
      endcase
    end
    // only the space map takes mcu writes; lock status is read only
    if (wr_ev && p_io && r.ready && p_addr[7:0] == OFS_SPACE_MAP) begin
      r_nxt.space_map = p_data; // RULE_20 RULE_02
    end
    // write command sequencer
    case (r.st)
      ST_LOAD: begin
        r_nxt.load_idx = r.load_idx + 2'h1;
        case (r.load_idx)
          NV_BOOT: r_nxt.main_prot = nv_rd_data; // RULE_23 RULE_01
          NV_MAP: begin
            r_nxt.boot_prot = nv_rd_data[3:0]; // RULE_23
            r_nxt.sec_bit   = nv_rd_data[BOOT_SEC_BIT];
          end
          NV_LAST: begin
            if (!r.ready) r_nxt.space_map = nv_rd_data; // RULE_20
            r_nxt.ready = 1'b1; // RULE_23
            r_nxt.st    = ST_READ;
          end
          default: ;
        endcase
      end
      ST_READ: begin
        if (tp_ev) begin
          r_nxt.st = ST_LOAD; // RULE_02
          r_nxt.load_idx = NV_MAIN;
        end else if (wr_ev && t_any && p_addr == UNLK_ADDR1 &&
                     p_data == UNLK_DATA1) begin
          r_nxt.st = ST_UNLK1; // RULE_05
        end
      end
      ST_UNLK1: if (wr_ev) begin
        r_nxt.st = (p_addr == UNLK_ADDR2 && p_data == UNLK_DATA2) ?
                   ST_UNLK2 : ST_READ; // RULE_05
      end
      ST_UNLK2: if (wr_ev) begin
        case (p_data)
          CMD_PROG:  r_nxt.st = ST_PDATA;
          CMD_ERASE: r_nxt.st = ST_ERS0;
          default:   r_nxt.st = ST_READ; // RULE_05
        endcase
      end
      ST_PDATA: if (wr_ev) begin
        r_nxt.st = ST_READ;
        if (t_any && !t_prot) begin // RULE_03 RULE_01
          r_nxt.prog  = 1'b1;
          r_nxt.st    = ST_PROG;
          r_nxt.tboot = t_boot;
          r_nxt.tsec  = t_idx;
          r_nxt.taddr = p_addr;
          r_nxt.tdata = p_data;
        end
      end
      ST_ERS0: if (wr_ev) begin
        r_nxt.st = (p_addr == UNLK_ADDR1 && p_data == UNLK_DATA1) ?
                   ST_ERS1 : ST_READ;
      end
      ST_ERS1: if (wr_ev) begin
        r_nxt.st = (p_addr == UNLK_ADDR2 && p_data == UNLK_DATA2) ?
                   ST_ERS2 : ST_READ;
      end
      ST_ERS2: if (wr_ev) begin
        r_nxt.st = ST_READ;
        r_nxt.tboot = t_boot;
        r_nxt.tsec  = t_idx;
        r_nxt.taddr = p_addr;
        if (p_data == CMD_BULK && t_any && !bank_prot) begin // RULE_03
          r_nxt.erase = 1'b1;
          r_nxt.bulk  = 1'b1;
          r_nxt.st    = ST_BULK;
        end else if (p_data == CMD_SECT && t_any && !t_prot) begin // RULE_03
          r_nxt.erase = 1'b1;
          r_nxt.bulk  = 1'b0;
          r_nxt.st    = ST_SECT;
        end
      end
      ST_PROG, ST_BULK, ST_SECT: begin
        // reset commands leave program and bulk erase running
        if (is_reset && r.st == ST_SECT) begin // RULE_08 RULE_10
          r_nxt.abort = 1'b1;
          r_nxt.st    = ST_RECOVER;
          r_nxt.cnt   = NEWER_VARIANT ? REC_NEW : REC_OLD;
        end else if (fl_fail_i) begin
          r_nxt.err = 1'b1;
          r_nxt.st  = ST_ERR;
        end else if (fl_done_i) begin
          r_nxt.st = ST_READ; // RULE_07
        end
      end
      ST_ERR: if (is_reset) begin
        r_nxt.abort = 1'b1; // RULE_09 RULE_06
        r_nxt.st    = ST_RECOVER;
        r_nxt.cnt   = NEWER_VARIANT ? REC_NEW : REC_OLD;
      end
      ST_RECOVER: begin
        r_nxt.cnt = r.cnt - 16'h0001;
        if (r.cnt <= 16'h0001) begin
          r_nxt.err = 1'b0; // RULE_09 RULE_10
          r_nxt.st  = ST_READ;
        end
      end
      default: r_nxt.st = ST_READ;
    endcase
    // read mode kept in a flip-flop so the pin is registered
    r_nxt.rmode = (r_nxt.st == ST_READ); // RULE_11
    // cycles spent in recovery, for the 25 us bound
    r_nxt.rec_seen = (r.st == ST_RECOVER) ? r.rec_seen + 16'h0001 : 16'h0000;
  end

  // state register; reset pin aborts the array and restarts the protection load, which ends in read mode
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r       <= '0;
      r.st    <= ST_LOAD;
      r.abort <= 1'b1; // RULE_11
    end else begin
      r <= r_nxt;
    end
  end

  // outputs straight from the state register
  assign bus_ready_o  = r.ready;
  assign rd_data_o    = r.rd_data;
  assign rd_valid_o   = r.rd_valid;
  assign sel_main_o   = r.sel_main;
  assign sel_boot_o   = r.sel_boot;
  assign sel_ram_o    = r.sel_ram;
  assign sel_io_o     = r.sel_io;
  assign sel_periph_o = r.sel_per;
  assign fl_prog_o    = r.prog;
  assign fl_erase_o   = r.erase;
  assign fl_bulk_o    = r.bulk;
  assign fl_abort_o   = r.abort;
  assign fl_boot_o    = r.tboot;
  assign fl_sector_o  = r.tsec;
  assign fl_addr_o    = r.taddr;
  assign fl_data_o    = r.tdata;
  assign error_flag_bit_o = r.err;
  assign read_mode_o  = r.rmode;

  a_prog_not_prot: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_03
    fl_prog_o |-> !(fl_boot_o ? r.boot_prot[fl_sector_o[1:0]] : r.main_prot[fl_sector_o]))
    else $error("program issued to a protected sector");
  a_lock_bus_stable: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_02
    (r.st != ST_LOAD) && !(r.st == ST_READ && tp_ev) |=> $stable(r.main_prot))
    else $error("lock status changed outside a test port load");
  a_busy_reset_ign: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_07
    (r.st inside {ST_PROG, ST_BULK}) && is_reset |=> r.st != ST_RECOVER)
    else $error("reset command aborted program or bulk erase");
  a_sect_abort: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_08
    r.st == ST_SECT && is_reset |=> fl_abort_o && r.st == ST_RECOVER)
    else $error("reset command did not abort sector erase");
  a_recover_bound: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_09
    NEWER_VARIANT |-> r.rec_seen <= REC_NEW)
    else $error("read mode not reached within 25 us");
  a_boot_over_main: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_16
    $past(t_boot) |-> sel_main_o == 8'h00)
    else $error("main sector selected over a boot sector");
  a_ram_wins: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_17
    $past(high_lvl) |-> sel_main_o == 8'h00 && sel_boot_o == 4'h0)
    else $error("flash selected over sram or io space");
  a_main_status: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_13
    rd_ev && p_rd && p_io && r.ready && p_addr[7:0] == OFS_MAIN_LOCK
    |=> rd_valid_o && rd_data_o == $past(r.main_prot))
    else $error("main lock status read returned wrong data");
  a_fetch_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_21
    $past(p_pf) && !$past(r.space_map[MAP_PF_RAM]) |-> !sel_ram_o)
    else $error("program fetch reached sram while gated off");
endmodule // fprs_top

/* File: verif/fprs_mcu_model.sv */
/*
  mcu bus model: byte writes, data reads and program fetches, one at a time.
  assumes the bench calls xfer from one process and sets the selects first.
*/
`timescale 1ns/10ps
module fprs_mcu_model (
  // clock
  input  wire logic        ref_clk_i,
  // resolved selects as seen on the bus
  input  wire logic [14:0] sel_i,
  // mcu pins
  output logic      [15:0] addr_o,
  output logic      [7:0]  data_o,
  output logic             wr_b_o,
  output logic             rd_b_o,
  output logic             pf_b_o,
  // select snapshot taken at the end of the strobe
  output logic      [14:0] sel_seen_o
);
  // idle bus at time zero
  initial begin
    addr_o = 16'h0000;
    data_o = 8'h00;
    wr_b_o = 1'b1;
    rd_b_o = 1'b1;
    pf_b_o = 1'b1;
    sel_seen_o = 15'h0000;
  end

  // kind 0 write, 1 data read, 2 fetch; strobe low 5 cycles, high 4 cycles
  task automatic xfer(input logic [1:0] kind, input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    addr_o = a;
    data_o = d;
    wr_b_o = (kind != 2'h0);
    rd_b_o = (kind != 2'h1);
    pf_b_o = (kind != 2'h2);
    repeat (5) @(negedge ref_clk_i);
    sel_seen_o = sel_i;
    wr_b_o = 1'b1;
    rd_b_o = 1'b1;
    pf_b_o = 1'b1;
    data_o = ~d; // released data lines do not keep the last value
    repeat (4) @(negedge ref_clk_i);
  endtask
endmodule // fprs_mcu_model

/* File: verif/fprs_top_tb.sv */
/*
  self-checking bench for the flash protect, reset and select block.
  assumes the mcu model drives the bus pins and the bench plays array and test port.
*/
`timescale 1ns/10ps
module fprs_top_tb;
  import fprs_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [7:0]  msel = 8'h00, tp_data = 8'h00;
  logic [3:0]  bsel = 4'h0;
  logic        ram = 1'b0, io = 1'b0, per = 1'b0, tp_wr = 1'b0, done = 1'b0, fail = 1'b0;
  logic [1:0]  tp_addr = 2'h0;
  logic [15:0] addr;
  logic [7:0]  data, rd_data_o, sel_main_o, fl_data_o;
  logic        wr_b, rd_b, pf_b, bus_ready_o, rd_valid_o, sel_ram_o, sel_io_o, sel_periph_o;
  logic [14:0] seen;
  logic [3:0]  sel_boot_o;
  logic        fl_prog_o, fl_erase_o, fl_bulk_o, fl_abort_o, fl_boot_o;
  logic        error_flag_bit_o, read_mode_o;
  logic [2:0]  fl_sector_o;
  logic [15:0] fl_addr_o;
  int          mismatches = 0, checked = 0, n_prog = 0, n_ers = 0, n_abt = 0, n_rdv = 0;
  int          a0;

  always #25 ref_clk_i = ~ref_clk_i;

  fprs_top #(.NEWER_VARIANT(1'b1), .OLD_RST_CYC(20)) dut (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .bus_addr_i(addr), .bus_data_i(data),
    .wr_strobe_b_i(wr_b), .rd_strobe_b_i(rd_b), .program_fetch_strobe_b_i(pf_b),
    .main_sector_selects_i(msel), .boot_sector_selects_i(bsel), .ram_select_i(ram),
    .config_io_space_i(io), .periph_select_i(per), .tp_wr_i(tp_wr), .tp_addr_i(tp_addr),
    .tp_data_i(tp_data), .fl_done_i(done), .fl_fail_i(fail), .bus_ready_o(bus_ready_o),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .sel_main_o(sel_main_o),
    .sel_boot_o(sel_boot_o), .sel_ram_o(sel_ram_o), .sel_io_o(sel_io_o),
    .sel_periph_o(sel_periph_o), .fl_prog_o(fl_prog_o), .fl_erase_o(fl_erase_o),
    .fl_bulk_o(fl_bulk_o), .fl_abort_o(fl_abort_o), .fl_boot_o(fl_boot_o),
    .fl_sector_o(fl_sector_o), .fl_addr_o(fl_addr_o), .fl_data_o(fl_data_o),
    .error_flag_bit_o(error_flag_bit_o), .read_mode_o(read_mode_o));

  fprs_mcu_model mcu (
    .ref_clk_i(ref_clk_i),
    .sel_i({sel_ram_o, sel_io_o, sel_periph_o, sel_boot_o, sel_main_o}),
    .addr_o(addr), .data_o(data), .wr_b_o(wr_b), .rd_b_o(rd_b), .pf_b_o(pf_b),
    .sel_seen_o(seen));

  // pulse counters: a pulse longer than one cycle counts once per cycle it is high
  always @(posedge ref_clk_i) begin
    if (fl_prog_o === 1'b1) n_prog <= n_prog + 1;
    if (fl_erase_o === 1'b1) n_ers <= n_ers + 1;
    if (fl_abort_o === 1'b1) n_abt <= n_abt + 1;
    if (rd_valid_o === 1'b1) n_rdv <= n_rdv + 1;
  end

  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  // decode array selects change on the falling edge
  task automatic sel(input logic [7:0] m, input logic [3:0] b, input logic r, i, p);
    @(negedge ref_clk_i);
    msel = m;
    bsel = b;
    ram = r;
    io = i;
    per = p;
  endtask

  task automatic tp(input logic [1:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    tp_addr = a;
    tp_data = d;
    tp_wr = 1'b1;
    @(negedge ref_clk_i);
    tp_wr = 1'b0;
    repeat (4) @(negedge ref_clk_i);
  endtask

  task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] d);
    sel(8'h00, 4'h0, 1'b0, 1'b1, 1'b0);
    mcu.xfer(2'h0, {8'h00, ofs}, d);
  endtask

  // one read gives one valid pulse and the expected byte
  task automatic reg_rd(input logic [7:0] ofs, input logic [7:0] exp);
    int v;
    v = n_rdv;
    sel(8'h00, 4'h0, 1'b0, 1'b1, 1'b0);
    mcu.xfer(2'h1, {8'h00, ofs}, 8'h00);
    check(rd_data_o, exp);
    check(n_rdv, v + 1);
  endtask

  task automatic selchk(input logic [1:0] k, input logic [7:0] map, m, input logic [3:0] b,
                        input logic r, i, p, input logic [14:0] exp);
    reg_wr(OFS_SPACE_MAP, map);
    sel(m, b, r, i, p);
    mcu.xfer(k, 16'h2000, 8'h00);
    check(seen, exp);
  endtask

  task automatic cmd(input logic [15:0] a, input logic [7:0] d);
    mcu.xfer(2'h0, a, d);
  endtask

  task automatic unlk();
    cmd(UNLK_ADDR1, UNLK_DATA1);
    cmd(UNLK_ADDR2, UNLK_DATA2);
  endtask

  task automatic prog(input logic [15:0] a, input logic [7:0] d);
    unlk();
    cmd(UNLK_ADDR1, CMD_PROG);
    cmd(a, d);
  endtask

  task automatic erase(input logic [7:0] code, input logic [15:0] a);
    unlk();
    cmd(UNLK_ADDR1, CMD_ERASE);
    unlk();
    cmd(a, code);
  endtask

  task automatic wait_idle(input int n);
    for (int k = 0; k < n && (read_mode_o !== 1'b1 || bus_ready_o !== 1'b1); k++)
      @(negedge ref_clk_i);
  endtask

  task automatic pulse_done_fail(input logic f);
    @(negedge ref_clk_i);
    done = ~f;
    fail = f;
    @(negedge ref_clk_i);
    done = 1'b0;
    fail = 1'b0;
    repeat (2) @(negedge ref_clk_i);
  endtask

  // watchdog sized well above the expected run
  initial begin
    #(60000 * 50);
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (4) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    wait_idle(40);
    check({bus_ready_o, read_mode_o}, 2'b11);
    repeat (3) @(negedge ref_clk_i);
    a0 = n_abt;
    tp(NV_MAIN, 8'h05);
    tp(NV_BOOT, 8'h82);
    // protection status, read only
    reg_rd(OFS_MAIN_LOCK, 8'h05);
    reg_rd(OFS_BOOT_LOCK, 8'h82);
    reg_wr(OFS_MAIN_LOCK, 8'hFA);
    reg_wr(OFS_BOOT_LOCK, 8'h7D);
    reg_rd(OFS_MAIN_LOCK, 8'h05);
    reg_rd(OFS_BOOT_LOCK, 8'h82);
    reg_rd(8'hC4, 8'h00);
    reg_rd(OFS_SPACE_MAP, 8'h0C);
    // select priority and space mapping
    selchk(2'h1, 8'h0C, 8'h02, 4'h0, 1'b1, 1'b0, 1'b0, 15'h4000);
    selchk(2'h1, 8'h0C, 8'h02, 4'h0, 1'b0, 1'b1, 1'b0, 15'h2000);
    selchk(2'h1, 8'h0C, 8'h02, 4'h1, 1'b0, 1'b0, 1'b0, 15'h0100);
    selchk(2'h1, 8'h0C, 8'h02, 4'h0, 1'b0, 1'b0, 1'b0, 15'h0000);
    selchk(2'h2, 8'h0C, 8'h02, 4'h0, 1'b0, 1'b0, 1'b0, 15'h0002);
    selchk(2'h2, 8'h0C, 8'h00, 4'h1, 1'b1, 1'b0, 1'b0, 15'h0000);
    selchk(2'h1, 8'h1F, 8'h02, 4'h0, 1'b0, 1'b0, 1'b0, 15'h0002);
    selchk(2'h1, 8'h1F, 8'h00, 4'h0, 1'b0, 1'b0, 1'b1, 15'h0000);
    selchk(2'h1, 8'h9F, 8'h02, 4'h0, 1'b0, 1'b0, 1'b1, 15'h1000);
    selchk(2'h2, 8'h9F, 8'h00, 4'h0, 1'b1, 1'b0, 1'b0, 15'h4000);
    selchk(2'h1, 8'h1F, 8'h01, 4'h0, 1'b0, 1'b0, 1'b0, 15'h0001);
    reg_wr(OFS_SPACE_MAP, 8'h0C);
    // program of an open sector, then reset command while it runs
    sel(8'h02, 4'h0, 1'b0, 1'b0, 1'b0);
    prog(16'h2000, 8'h3C);
    check(n_prog, 1);
    check({fl_boot_o, fl_sector_o, fl_data_o}, {4'h0, 1'b0, 3'h1, 8'h3C});
    check(fl_addr_o, 16'h2000);
    cmd(16'h0000, CMD_RESET);
    check(read_mode_o, 1'b0);
    check(n_abt, a0);
    pulse_done_fail(1'b0);
    check(read_mode_o, 1'b1);
    // protected sector and bulk erase of a bank with protection
    sel(8'h01, 4'h0, 1'b0, 1'b0, 1'b0);
    prog(16'h0100, 8'h11);
    check(n_prog, 1);
    check(read_mode_o, 1'b1);
    sel(8'h02, 4'h0, 1'b0, 1'b0, 1'b0);
    erase(CMD_BULK, 16'h2000);
    check(n_ers, 0);
    // sector erase aborted by a single reset write
    erase(CMD_SECT, 16'h2000);
    check(n_ers, 1);
    check({fl_bulk_o, read_mode_o}, 2'b00);
    cmd(16'h0000, CMD_RESET);
    check(n_abt, a0 + 1);
    wait_idle(RECOVER_CYC + 5);
    check(read_mode_o, 1'b1);
    // failed program, then reset command with unlock prefix
    prog(16'h2001, 8'h0F);
    pulse_done_fail(1'b1);
    check(error_flag_bit_o, 1'b1);
    unlk();
    cmd(16'h0000, CMD_RESET);
    wait_idle(RECOVER_CYC + 5);
    check({error_flag_bit_o, read_mode_o}, 2'b01);
    // reset pin in mid program
    prog(16'h2002, 8'h55);
    check(read_mode_o, 1'b0);
    @(negedge ref_clk_i);
    rst_b_i = 1'b0;
    repeat (RECOVER_CYC) @(negedge ref_clk_i);
    check(fl_abort_o, 1'b1);
    rst_b_i = 1'b1;
    wait_idle(40);
    check(read_mode_o, 1'b1);
    repeat (3) @(negedge ref_clk_i);
    reg_rd(OFS_MAIN_LOCK, 8'h05);
    reg_rd(OFS_SPACE_MAP, 8'h0C);
    // bulk erase of a fully open bank; a reset command leaves it running
    tp(NV_MAIN, 8'h00);
    sel(8'h02, 4'h0, 1'b0, 1'b0, 1'b0);
    erase(CMD_BULK, 16'h2000);
    check(n_ers, 2);
    check(fl_bulk_o, 1'b1);
    cmd(16'h0000, CMD_RESET);
    check(read_mode_o, 1'b0);
    stop_test();
  end
endmodule // fprs_top_tb
